/* File: tlx_exec.sv */
// Execution unit: table latch moves, program memory write, test-skip and xor
//
// Overview of operation
// [RULE1] A program memory write loads file register f into the latch half chosen by t, then writes the full 16-bit latch at the pointer.
// [RULE2] On a program memory write, i high bumps the table pointer by one after the write and i low leaves it alone.
// [RULE3] A program memory write takes two cycles, or stays busy until the write is done when the target is on-chip memory.
// [RULE4] Latch byte read (1010 00tx) copies the low (t=0) or high (t=1) latch byte to f in one cycle, latch untouched.
// [RULE5] Latch byte write (1010 01tx) puts f in the low (t=0) or high (t=1) latch byte in one cycle, other byte and flags kept.
// [RULE6] Test-zero-skip (0011 0011) discards the fetched next instruction when f is zero, costing two cycles, flags kept.
// [RULE7] Literal xor (1011 0100) xors the working register with k, result to the working register, zero flag updated.
// [RULE8] File xor (0000 110d) xors the working register with f, result to the working register (d=0) or f (d=1), zero flag updated.
// [RULE9] The table latch is 16 bits made of separately addressable high and low bytes.
// [RULE10] An interrupt ends an on-chip program memory write early.
// [RULE11] The unused x bit of the latch byte read and write opcodes is ignored.
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
module tlx_exec
  import tlx_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rstn,
  // Instruction issue from the core; fileRdData is the value of f
  input  wire logic              instrValid,
  input  wire logic [15:0]       instrWord,
  input  wire logic [7:0]        fileRdData,
  output logic                   busy_q,
  output logic                   skipNext_q,
  // File register write-back
  output logic                   fileWrEn_q,
  output logic      [7:0]        fileWrAddr_q,
  output logic      [7:0]        fileWrData_q,
  // Working register and zero flag
  output logic      [7:0]        workReg_q,
  output logic                   zeroFlag_q,
  // Program memory write port
  input  wire logic              pmOnChip,
  input  wire logic              pmWriteDone,
  input  wire logic              irqPending,
  output logic                   pmWrEn_q,
  output logic      [15:0]       pmAddr_q,
  output logic      [15:0]       pmWrData_q,
  // Register port
  input  wire logic [2:0]        regAddr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [7:0]        regRdData_q
);

  tlx_decode_s dec;
  tlx_state_e  state_q;
  tlx_state_e  state_d;
  logic [15:0] tablePointer_q;
  logic [15:0] tablePointer_d;
  logic [15:0] tableLatch_q;
  logic [15:0] tableLatch_d;
  logic [7:0]  workReg_d;
  logic        zeroFlag_d;
  logic        incrPtr_q;
  logic        aborted_q;
  logic [7:0]  xorOther;
  logic [7:0]  xorResult;
  logic        xorZero;
  logic        accept;
  logic        writeEnds;
  logic        writeAborts;
  logic        issueWrite;
  logic [7:0]  latchRdByte;
  logic [7:0]  statusByte;

  tlx_decode u_decode (
    .instrValid (instrValid),
    .instrWord  (instrWord),
    .dec        (dec)
  );

  assign xorOther = dec.xorLit ? dec.operand : fileRdData;

  tlx_xor_unit u_xor (
    .workIn  (workReg_q),
    .otherIn (xorOther),
    .result  (xorResult),
    .isZero  (xorZero)
  );

  // Issues arriving while a write is in flight are dropped; the core must honour busy
  assign accept = (state_q == ST_IDLE);

  // A taken program memory write starts the state machine, latch load and port together
  assign issueWrite = accept && dec.pmemWrite;

  // Byte handed to the file register by a latch read; t picks the half
  assign latchRdByte = dec.tBit ? tableLatch_q[15:8] : tableLatch_q[7:0];  // see [RULE4]

  // Off-chip writes finish after the second cycle; on-chip ones wait for done or interrupt
  always_comb begin
    writeEnds   = 1'b0;
    writeAborts = 1'b0;
    unique case (state_q)
      ST_IDLE:  writeEnds = 1'b0;
      ST_WRITE: writeEnds = !pmOnChip;                              // see [RULE3]
      ST_LONG: begin
        writeEnds   = pmWriteDone;                                  // see [RULE3]
        // Done beats a same-cycle interrupt, so such a write still counts as finished
        writeAborts = irqPending && !pmWriteDone;                   // see [RULE10]
      end
      default:  writeEnds = 1'b0;
    endcase
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:  if (issueWrite) state_d = ST_WRITE;
      ST_WRITE: state_d = pmOnChip ? ST_LONG : ST_IDLE;
      ST_LONG:  if (writeEnds || writeAborts) state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Latch byte update: instruction load wins over a register port write
  always_comb begin
    tableLatch_d = tableLatch_q;
    if (regWr && regAddr == ADDR_LAT_LO) begin
      tableLatch_d[7:0] = regWrData;
    end
    if (regWr && regAddr == ADDR_LAT_HI) begin
      tableLatch_d[15:8] = regWrData;
    end
    if (accept && (dec.latchWrite || dec.pmemWrite)) begin          // see [RULE5] [RULE1]
      if (dec.tBit) begin
        tableLatch_d[15:8] = fileRdData;                            // see [RULE9]
      end else begin
        tableLatch_d[7:0] = fileRdData;                             // see [RULE9]
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tableLatch_q <= LATCH_RST;
    end else begin
      tableLatch_q <= tableLatch_d;
    end
  end

  // Pointer increments only when a write with i set really completed, never on an interrupted one
  always_comb begin
    tablePointer_d = tablePointer_q;
    if (regWr && regAddr == ADDR_PTR_LO) begin
      tablePointer_d[7:0] = regWrData;
    end
    if (regWr && regAddr == ADDR_PTR_HI) begin
      tablePointer_d[15:8] = regWrData;
    end
    if (writeEnds && incrPtr_q) begin
      tablePointer_d = tablePointer_q + 16'h0001;                   // see [RULE2]
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tablePointer_q <= PTR_RST;
    end else begin
      tablePointer_q <= tablePointer_d;
    end
  end

  // The i bit is kept for the whole write, so a late done still knows whether to step
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      incrPtr_q <= 1'b0;
    end else if (issueWrite) begin
      incrPtr_q <= dec.iBit;                                        // see [RULE2]
    end
  end

  // Program memory port: address and data stand for the whole write
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pmWrEn_q   <= 1'b0;
      pmAddr_q   <= PTR_RST;
      pmWrData_q <= LATCH_RST;
    end else if (issueWrite) begin
      pmWrEn_q   <= 1'b1;                                           // see [RULE1]
      pmAddr_q   <= tablePointer_q;
      pmWrData_q <= tableLatch_d;                                   // see [RULE1]
    end else if (writeEnds || writeAborts) begin
      pmWrEn_q   <= 1'b0;
    end
  end

  // Taken from the next state, so busy falls at the very edge a new issue can be taken
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_d != ST_IDLE);                               // see [RULE3]
    end
  end

  // Sticky until the next program memory write starts
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      aborted_q <= 1'b0;
    end else if (writeAborts) begin
      aborted_q <= 1'b1;                                            // see [RULE10]
    end else if (issueWrite) begin
      aborted_q <= 1'b0;
    end
  end

  // Skip pulse tells the core to turn the fetched instruction into a no-op
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      skipNext_q <= 1'b0;
    end else begin
      skipNext_q <= accept && dec.testSkip && (fileRdData == 8'h00); // see [RULE6]
    end
  end

  // File register write-back
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fileWrEn_q   <= 1'b0;
      fileWrAddr_q <= 8'h00;
      fileWrData_q <= 8'h00;
    end else begin
      fileWrEn_q   <= 1'b0;
      if (accept && dec.latchRead) begin
        fileWrEn_q   <= 1'b1;                                       // see [RULE4]
        fileWrAddr_q <= dec.operand;
        fileWrData_q <= latchRdByte;                                // see [RULE4]
      end else if (accept && dec.xorFile && dec.dBit) begin
        fileWrEn_q   <= 1'b1;                                       // see [RULE8]
        fileWrAddr_q <= dec.operand;
        fileWrData_q <= xorResult;
      end
    end
  end

  // Working register and zero flag; only the xor forms and a status register write touch the flag
  always_comb begin
    workReg_d  = workReg_q;
    zeroFlag_d = zeroFlag_q;
    if (regWr && regAddr == ADDR_WORK) begin
      workReg_d = regWrData;
    end
    if (regWr && regAddr == ADDR_STATUS) begin
      zeroFlag_d = regWrData[STAT_ZERO_BIT];
    end
    if (accept && dec.xorLit) begin
      workReg_d  = xorResult;                                       // see [RULE7]
      zeroFlag_d = xorZero;                                         // see [RULE7]
    end
    if (accept && dec.xorFile) begin
      if (!dec.dBit) begin
        workReg_d = xorResult;                                      // see [RULE8]
      end
      zeroFlag_d = xorZero;                                         // see [RULE8]
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      workReg_q  <= WORK_RST;
      zeroFlag_q <= 1'b0;
    end else begin
      workReg_q  <= workReg_d;
      zeroFlag_q <= zeroFlag_d;
    end
  end

  // Busy and aborted are read-only, so a status write reaches only the zero bit
  always_comb begin
    statusByte                 = 8'h00;
    statusByte[STAT_ZERO_BIT]  = zeroFlag_q;
    statusByte[STAT_BUSY_BIT]  = busy_q;
    statusByte[STAT_ABORT_BIT] = aborted_q;                         // see [RULE10]
  end

  // Register port read, data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      regRdData_q <= 8'h00;
    end else if (regRd) begin
      unique case (regAddr)
        ADDR_PTR_LO: regRdData_q <= tablePointer_q[7:0];
        ADDR_PTR_HI: regRdData_q <= tablePointer_q[15:8];
        ADDR_LAT_LO: regRdData_q <= tableLatch_q[7:0];
        ADDR_LAT_HI: regRdData_q <= tableLatch_q[15:8];
        ADDR_WORK:   regRdData_q <= workReg_q;
        ADDR_STATUS: regRdData_q <= statusByte;
        default:     regRdData_q <= 8'h00;
      endcase
    end else begin
      regRdData_q <= 8'h00;
    end
  end

endmodule

/* File: tlx_pkg.sv */
// Shared constants, decode fields and states for the table latch execution unit
package tlx_pkg;

  localparam int          DATA_W     = 8;
  localparam int          PTR_W      = 16;
  localparam int          REG_ADDR_W = 3;

  // Register map, one byte per address
  localparam logic [2:0]  ADDR_PTR_LO = 3'h0;
  localparam logic [2:0]  ADDR_PTR_HI = 3'h1;
  localparam logic [2:0]  ADDR_LAT_LO = 3'h2;
  localparam logic [2:0]  ADDR_LAT_HI = 3'h3;
  localparam logic [2:0]  ADDR_WORK   = 3'h4;
  localparam logic [2:0]  ADDR_STATUS = 3'h5;

  // Status register bit positions
  localparam int          STAT_ZERO_BIT  = 0;
  localparam int          STAT_BUSY_BIT  = 1;
  localparam int          STAT_ABORT_BIT = 2;

  // Reset values
  localparam logic [15:0] PTR_RST   = 16'h0000;
  localparam logic [15:0] LATCH_RST = 16'h0000;
  localparam logic [7:0]  WORK_RST  = 8'h00;

  // Opcode patterns, compared on the upper bits of the instruction word
  localparam logic [5:0]  OPC_PMEM_WRITE = 6'h2B;  // 1010 11ti
  localparam logic [5:0]  OPC_LATCH_RD   = 6'h28;  // 1010 00tx
  localparam logic [5:0]  OPC_LATCH_WR   = 6'h29;  // 1010 01tx
  localparam logic [7:0]  OPC_TEST_SKIP  = 8'h33;  // 0011 0011
  localparam logic [7:0]  OPC_XOR_LIT    = 8'hB4;  // 1011 0100
  localparam logic [6:0]  OPC_XOR_FILE   = 7'h06;  // 0000 110d

  // Field positions in the instruction word
  localparam int          T_BIT_POS = 9;
  localparam int          I_BIT_POS = 8;
  localparam int          D_BIT_POS = 8;

  typedef struct packed {
    logic       pmemWrite;
    logic       latchRead;
    logic       latchWrite;
    logic       testSkip;
    logic       xorLit;
    logic       xorFile;
    logic       tBit;
    logic       iBit;
    logic       dBit;
    logic [7:0] operand;
  } tlx_decode_s;

  // Gray coded along idle -> write -> long write
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WRITE = 2'b01,
    ST_LONG  = 2'b11
  } tlx_state_e;

endpackage

/* File: tlx_decode.sv */
// Instruction word decoder for the table latch, test-skip and exclusive-OR group
module tlx_decode
  import tlx_pkg::*;
(
  input  wire logic        instrValid,
  input  wire logic [15:0] instrWord,
  output tlx_decode_s      dec
);

  always_comb begin
    dec            = '0;
    dec.operand    = instrWord[7:0];
    dec.tBit       = instrWord[T_BIT_POS];
    dec.iBit       = instrWord[I_BIT_POS];
    dec.dBit       = instrWord[D_BIT_POS];
    if (instrValid) begin
      dec.pmemWrite  = (instrWord[15:10] == OPC_PMEM_WRITE);
      // Bit 8 is a don't-care for both latch byte moves
      dec.latchRead  = (instrWord[15:10] == OPC_LATCH_RD);   // see [RULE11]
      dec.latchWrite = (instrWord[15:10] == OPC_LATCH_WR);   // see [RULE11]
      dec.testSkip   = (instrWord[15:8] == OPC_TEST_SKIP);
      dec.xorLit     = (instrWord[15:8] == OPC_XOR_LIT);
      dec.xorFile    = (instrWord[15:9] == OPC_XOR_FILE);
    end
  end

endmodule

/* File: tlx_xor_unit.sv */
// Exclusive-OR datapath with zero detect, shared by both xor forms
module tlx_xor_unit
  import tlx_pkg::*;
(
  input  wire logic [7:0] workIn,
  input  wire logic [7:0] otherIn,
  output logic      [7:0] result,
  output logic            isZero
);

  always_comb begin
    result = workIn ^ otherIn;
    isZero = (result == 8'h00);
  end

endmodule

/* File: tlx_pmem_model.sv */
// Program memory model: takes table writes, answers on-chip writes late
module tlx_pmem_model (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        pmOnChip,
  input  wire logic [3:0]  lat,
  input  wire logic        pmWrEn_q,
  input  wire logic [15:0] pmAddr_q,
  input  wire logic [15:0] pmWrData_q,
  output logic             pmWriteDone
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [256];
  logic [3:0]  cnt;
  // Off-chip writes never see a done pulse; they end on their own
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 4'h0;
      pmWriteDone <= 1'b0;
    end else begin
      pmWriteDone <= pmWrEn_q && pmOnChip && cnt == lat && !pmWriteDone;
      cnt <= pmWrEn_q ? cnt + 4'h1 : 4'h0;
      if (pmWrEn_q && cnt == 4'h0) begin
        mem[pmAddr_q[7:0]] <= pmWrData_q;
      end
    end
  end
endmodule

/* File: tlx_exec_assertions.sv */
// Port-level checks of the execution unit
module tlx_exec_assertions (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        instrValid,
  input wire logic [15:0] instrWord,
  input wire logic [7:0]  fileRdData,
  input wire logic        busy_q,
  input wire logic        skipNext_q,
  input wire logic        fileWrEn_q,
  input wire logic [7:0]  fileWrData_q,
  input wire logic [7:0]  workReg_q,
  input wire logic        zeroFlag_q,
  input wire logic        pmOnChip,
  input wire logic        regWr,
  input wire logic        pmWrEn_q,
  input wire logic [15:0] pmWrData_q
);
  logic       go;
  logic [7:0] op;
  logic [7:0] lit;
  // Register writes may touch the zero flag, so they mask the checks
  assign go  = instrValid && !busy_q && !regWr;
  assign op  = instrWord[15:8];
  assign lit = instrWord[7:0];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_skip;
    go && op == 8'h33 && fileRdData == 8'h00 |=> skipNext_q ##1 !skipNext_q;
  endproperty
  a_skip: assert property (p_skip) else $error("skip pulse wrong");
  property p_noskip;
    go && op == 8'h33 && fileRdData != 8'h00 |=> !skipNext_q && $stable(zeroFlag_q);
  endproperty
  a_noskip: assert property (p_noskip) else $error("skip on nonzero");
  property p_xlit;
    go && op == 8'hB4 |=> workReg_q == ($past(workReg_q) ^ $past(lit))
      && zeroFlag_q == (workReg_q == 8'h00);
  endproperty
  a_xlit: assert property (p_xlit) else $error("literal xor wrong");
  property p_xzero;
    go && op[7:1] == 7'h06 |=> zeroFlag_q == (($past(workReg_q) ^ $past(fileRdData)) == 8'h00);
  endproperty
  a_xzero: assert property (p_xzero) else $error("file xor zero wrong");
  property p_xd1;
    go && op == 8'h0D |=> fileWrEn_q && $stable(workReg_q)
      && fileWrData_q == ($past(workReg_q) ^ $past(fileRdData));
  endproperty
  a_xd1: assert property (p_xd1) else $error("file xor to f wrong");
  property p_lrd;
    go && op[7:2] == 6'h28 |=> fileWrEn_q && $stable(zeroFlag_q);
  endproperty
  a_lrd: assert property (p_lrd) else $error("latch read no write");
  property p_lwt;
    go && op[7:2] == 6'h29 |=> !fileWrEn_q && $stable(zeroFlag_q) && $stable(workReg_q);
  endproperty
  a_lwt: assert property (p_lwt) else $error("latch write side effect");
  property p_pmw;
    go && op[7:1] == 7'h57 |=> pmWrEn_q && busy_q && pmWrData_q[15:8] == $past(fileRdData);
  endproperty
  a_pmw: assert property (p_pmw) else $error("write data wrong");
  property p_pmoff;
    go && op[7:2] == 6'h2B && !pmOnChip |=> busy_q ##1 !busy_q && !pmWrEn_q;
  endproperty
  a_pmoff: assert property (p_pmoff) else $error("write not two cycles");
endmodule

bind tlx_exec tlx_exec_assertions u_chk (
  .mclk(mclk), .rstn(rstn), .instrValid(instrValid), .instrWord(instrWord),
  .fileRdData(fileRdData), .busy_q(busy_q), .skipNext_q(skipNext_q),
  .fileWrEn_q(fileWrEn_q), .fileWrData_q(fileWrData_q), .workReg_q(workReg_q),
  .zeroFlag_q(zeroFlag_q), .pmOnChip(pmOnChip), .regWr(regWr),
  .pmWrEn_q(pmWrEn_q), .pmWrData_q(pmWrData_q)
);

/* File: tlx_exec_bench.sv */
// Self-checking bench for the table latch execution unit
module tlx_exec_bench;
  import tlx_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rstn = 1'b0, instrValid = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic pmOnChip = 1'b0, irqPending = 1'b0, pmWriteDone;
  logic [15:0] instrWord = 16'h0000, pmAddr_q, pmWrData_q;
  logic [7:0]  fileRdData = 8'h00, regWrData = 8'h00;
  logic [2:0]  regAddr = 3'h0;
  logic [3:0]  lat = 4'h4;
  logic busy_q, skipNext_q, fileWrEn_q, zeroFlag_q, pmWrEn_q;
  logic [7:0]  fileWrAddr_q, fileWrData_q, workReg_q, regRdData_q;
  int n_fail = 0;
  int compares = 0;
  int n;
  always #50 mclk = ~mclk;
  tlx_exec u_tlx_exec (.mclk(mclk), .rstn(rstn), .instrValid(instrValid),
    .instrWord(instrWord), .fileRdData(fileRdData), .busy_q(busy_q),
    .skipNext_q(skipNext_q), .fileWrEn_q(fileWrEn_q), .fileWrAddr_q(fileWrAddr_q),
    .fileWrData_q(fileWrData_q), .workReg_q(workReg_q), .zeroFlag_q(zeroFlag_q),
    .pmOnChip(pmOnChip), .pmWriteDone(pmWriteDone), .irqPending(irqPending),
    .pmWrEn_q(pmWrEn_q), .pmAddr_q(pmAddr_q), .pmWrData_q(pmWrData_q),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData_q(regRdData_q));
  tlx_pmem_model u_tlx_pmem_model (.mclk(mclk), .rstn(rstn), .pmOnChip(pmOnChip),
    .lat(lat), .pmWrEn_q(pmWrEn_q), .pmAddr_q(pmAddr_q), .pmWrData_q(pmWrData_q),
    .pmWriteDone(pmWriteDone));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // The value line is scrambled once the word is no longer valid
  task automatic ins(input logic [15:0] w, input logic [7:0] f);
    @(posedge mclk);
    instrValid <= 1'b1;
    instrWord <= w;
    fileRdData <= f;
    @(posedge mclk);
    instrValid <= 1'b0;
    fileRdData <= ~f;
    #1;
  endtask
  task automatic rw(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rr(input string nm, input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    chk(nm, {8'h00, e}, {8'h00, regRdData_q});
  endtask
  task automatic t_latch();
    rr("ptrRst", ADDR_PTR_HI, 8'h00);
    rr("unmapped", 3'h6, 8'h00);
    ins(16'hA421, 8'hB7);
    chk("lwtNoWr", 16'h0000, {15'h0000, fileWrEn_q});
    ins(16'hA721, 8'h53);
    rr("latLo", ADDR_LAT_LO, 8'hB7);
    rr("latHi", ADDR_LAT_HI, 8'h53);
    ins(16'hA321, 8'h00);
    chk("lrdHi", 16'h0153, {fileWrEn_q, fileWrData_q});
    ins(16'hA021, 8'h00);
    chk("lrdLo", 16'h21B7, {fileWrAddr_q, fileWrData_q});
    rr("latKeep", ADDR_LAT_HI, 8'h53);
  endtask
  task automatic t_xor();
    rw(ADDR_WORK, 8'hB5);
    ins(16'h0D21, 8'hAF);
    chk("xfD1", 16'h011A, {fileWrEn_q, fileWrData_q});
    chk("xfW", 16'h00B5, {8'h00, workReg_q});
    ins(16'hB4AF, 8'h00);
    chk("xl", 16'h001A, {zeroFlag_q, workReg_q});
    ins(16'h0C21, 8'h1A);
    chk("xfD0", 16'h0100, {fileWrEn_q, zeroFlag_q, workReg_q});
    rr("workRd", ADDR_WORK, 8'h00);
  endtask
  task automatic t_skip();
    ins(16'h3321, 8'h00);
    chk("skip", 16'h0101, {skipNext_q, 7'h00, zeroFlag_q});
    @(posedge mclk);
    #1;
    chk("skipEnd", 16'h0000, {15'h0000, skipNext_q});
    ins(16'h3321, 8'h01);
    chk("noSkip", 16'h0001, {skipNext_q, 7'h00, zeroFlag_q});
  endtask
  task automatic t_pmw();
    rw(ADDR_PTR_LO, 8'h56);
    rw(ADDR_PTR_HI, 8'hA3);
    rw(ADDR_LAT_LO, 8'h55);
    rw(ADDR_LAT_HI, 8'hAA);
    ins(16'hAF21, 8'h53);
    chk("pmAddr", 16'hA356, pmAddr_q);
    chk("pmData", 16'h5355, pmWrData_q);
    chk("busy", 16'h0003, {14'h0000, busy_q, pmWrEn_q});
    @(posedge mclk);
    #1;
    chk("end2", 16'h0000, {14'h0000, busy_q, pmWrEn_q});
    rr("ptrInc", ADDR_PTR_LO, 8'h57);
    chk("mem", 16'h5355, u_tlx_pmem_model.mem[8'h56]);
    ins(16'hAC21, 8'h53);
    chk("pmData0", 16'h5353, pmWrData_q);
    rr("ptrKeep", ADDR_PTR_LO, 8'h57);
  endtask
  task automatic t_onchip();
    @(posedge mclk);
    pmOnChip <= 1'b1;
    ins(16'hAD21, 8'h11);
    repeat (3) @(posedge mclk);
    #1;
    chk("longBusy", 16'h0001, {15'h0000, busy_q});
    // Outputs are looked at after the edge has settled them
    for (n = 0; n < 20 && busy_q; n++) begin
      @(posedge mclk);
      #1;
    end
    chk("longEnd", 16'h0000, {14'h0000, busy_q, pmWrEn_q});
    rr("ptrOn", ADDR_PTR_LO, 8'h58);
    lat <= 4'hF;
    ins(16'hAD21, 8'h22);
    repeat (2) @(posedge mclk);
    irqPending <= 1'b1;
    @(posedge mclk);
    irqPending <= 1'b0;
    #1;
    for (n = 0; n < 3 && busy_q; n++) begin
      @(posedge mclk);
      #1;
    end
    chk("irqEnd", 16'h0000, {14'h0000, busy_q, pmWrEn_q});
    rr("aborted", ADDR_STATUS, 8'h05);
    rr("ptrNoInc", ADDR_PTR_LO, 8'h58);
    rw(ADDR_STATUS, 8'h00);
    rr("zeroClr", ADDR_STATUS, 8'h04);
  endtask
  task automatic wrap_up();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    t_latch();
    t_xor();
    t_skip();
    t_pmw();
    t_onchip();
    wrap_up();
  end
  // Whole run is under a hundred cycles; the 2000-cycle limit leaves ample margin
  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end
endmodule
